// ===== pkg/sao_consts.svh
// Register map, field positions and reset values of the serial audio output port.
// Assumes inclusion by bare name from the design files.
`ifndef SAO_CONSTS_SVH
`define SAO_CONSTS_SVH
// ****************************************
// Register addresses
// ****************************************
`define SAO_ADDR_CFG1   32'h40005818
`define SAO_ADDR_RATE   32'h4000581C
`define SAO_ADDR_STAT   32'h40005820
`define SAO_ADDR_UPPER  32'h40005824
`define SAO_ADDR_LOWER  32'h40005828
// ****************************************
// Field positions and masks
// ****************************************
`define SAO_CFG1_MASK   16'hFFC1
`define SAO_RATE_MASK   16'h003F
`define SAO_RST_VAL     16'h0000
`define SAO_EN_BIT      0
`define SAO_CH1_BIT     6
`define SAO_CH2_BIT     7
`define SAO_MODE_LSB    8
`define SAO_DMA_EN_BIT  13
`define SAO_REQ_EN_BIT  12
`define SAO_FIFO_RST_BIT 15
`define SAO_SAMP_LSB    0
`define SAO_DMA_LSB     2
`define SAO_REQ_LSB     4
`define SAO_ERR_BIT     0
`define SAO_PEND_BIT    1
`define SAO_CNT_LSB     2
// ****************************************
// Sizes
// ****************************************
`define SAO_SAMPLE_W    24
`define SAO_FIFO_DEPTH  8
`define SAO_CNT_W       4
// ****************************************
// Divider tops, space thresholds, link idle
// ****************************************
`define SAO_DIV1_TOP    4'h0
`define SAO_DIV2_TOP    4'h1
`define SAO_DIV4_TOP    4'h3
`define SAO_DIV8_TOP    4'h7
`define SAO_DIV16_TOP   4'hF
`define SAO_THR_NONE    4'h0
`define SAO_THR_1       4'h1
`define SAO_THR_2       4'h2
`define SAO_THR_4       4'h4
`define SAO_THR_8       4'h8
`define SAO_SYNC_IDLE   3'h7
`endif

// ===== pkg/sao_pkg.sv
// Types shared by the serial audio output port.
// Assumes nothing of its surroundings.
package sao_pkg;
    // Sample transfer width selection
    typedef enum logic [1:0] {
        SAO_MODE_24 = 2'b00,
        SAO_MODE_16 = 2'b01,
        SAO_MODE_8 = 2'b10,
        SAO_MODE_RSV = 2'b11
    } sao_mode_t;
    // Channel slot being shifted
    typedef enum logic [1:0] {
        SAO_SLOT_CH1 = 2'b01,
        SAO_SLOT_CH2 = 2'b10
    } sao_slot_t;
endpackage

// ===== hdl/sao_top.sv
// Serial audio output port: register file, sample FIFO and frame shifter.
// Assumes word select and bit clock from the external converter, asynchronous.
//
// Notes on behaviour
// - Mode 00: 24-bit samples, two writes
// - Mode 01: 16-bit sample, one write
// - Mode 10: low byte sample n, high n+1
// - 8-bit mode: requests every two frames at request rate code 00
// - Bits 7/6 select channel 2/1 transfers
// - Reserved bits read back zero
// - Request rate: 1(2), 4, 8, 16 frames
// - DMA when free space 1(2), 4, 8
// - Output sampling: every 1, 4, 8, 16 frames
// - FIFO eight deep, full write discarded
// - Sticky underrun/overrun flag, write-one clears
// - Request flagged at frame start
`timescale 1ns/1ns
`include "sao_consts.svh"

// ****************************************
// Sample FIFO
// ****************************************
module sao_fifo
    import sao_pkg::*;
#(
    parameter int W = 24,
    parameter int D = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D+1)-1:0] count
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [$clog2(D+1)-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Pointer and count update; a push on full is dropped
    always_comb
    begin
        in_ready = (cnt_r != D[$clog2(D+1)-1:0]);
        out_valid = (cnt_r != '0);
        push = in_valid && in_ready;
        pop = out_ready && out_valid;
        wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        if (clr)
        begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
    end

    // Registers and storage
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push && !clr)
            mem_r[wp_r] <= in_data;
    end

    assign out_data = mem_r[rp_r];
    assign count = cnt_r;

    AST_FIFO_FULL_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
        (cnt_r == D[$clog2(D+1)-1:0] && in_valid && !out_ready && !clr) |=> cnt_r == $past(cnt_r))
        else $error("full fifo count changed on write");
endmodule // sao_fifo

// ****************************************
// Port top
// ****************************************
module sao_top
    import sao_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic word_sel,
    input wire logic bit_clk,
    output logic ser_data,
    output logic data_request_pending,
    output logic dma_req,
    output logic fifo_error_flag
);
    logic [15:0] cfg1_r, cfg1_nxt, rate_r, rate_nxt, rdata_r, rdata_nxt;
    logic [7:0] low_r, low_nxt, hi8_r, hi8_nxt;
    logic hi8_pend_r, hi8_pend_nxt, err_r, err_nxt, pend_r, pend_nxt;
    logic [2:0] ws_s_r, bc_s_r;
    logic [`SAO_CNT_W-1:0] req_cnt_r, req_cnt_nxt, samp_cnt_r, samp_cnt_nxt;
    logic [`SAO_SAMPLE_W-1:0] sh_r, sh_nxt, push_data, pop_data;
    logic [`SAO_SAMPLE_W-1:0] last_r [2];
    logic [`SAO_SAMPLE_W-1:0] last_nxt [2];
    logic take_r, take_nxt, sd_r, sd_nxt;
    logic push_v, fifo_rdy, pop_v, pop_req, frame_start, ws_rise, bc_fall;
    logic en, ch1, ch2;
    logic [`SAO_CNT_W-1:0] fcount, free, req_div, samp_div, dma_thr;
    sao_mode_t mode;

    // Divider count for a 2-bit rate code
    function automatic logic [`SAO_CNT_W-1:0] rate_top(input logic [1:0] code);
        case (code)
            2'b00: rate_top = `SAO_DIV1_TOP;
            2'b01: rate_top = `SAO_DIV4_TOP;
            2'b10: rate_top = `SAO_DIV8_TOP;
            default: rate_top = `SAO_DIV16_TOP;
        endcase
    endfunction

    // Field decode
    always_comb
    begin
        en = cfg1_r[`SAO_EN_BIT];
        ch1 = cfg1_r[`SAO_CH1_BIT];
        ch2 = cfg1_r[`SAO_CH2_BIT];
        mode = sao_mode_t'(cfg1_r[`SAO_MODE_LSB +: 2]);
        req_div = rate_top(rate_r[`SAO_REQ_LSB +: 2]);
        if (mode == SAO_MODE_8 && rate_r[`SAO_REQ_LSB +: 2] == 2'b00)
            req_div = `SAO_DIV2_TOP;
        samp_div = rate_top(rate_r[`SAO_SAMP_LSB +: 2]);
        free = 4'(`SAO_FIFO_DEPTH) - fcount;
        case (rate_r[`SAO_DMA_LSB +: 2])
            2'b00: dma_thr = (mode == SAO_MODE_8) ? `SAO_THR_2 : `SAO_THR_1;
            2'b01: dma_thr = `SAO_THR_4;
            2'b10: dma_thr = `SAO_THR_8;
            default: dma_thr = `SAO_THR_NONE;
        endcase
        dma_req = en && cfg1_r[`SAO_DMA_EN_BIT] && dma_thr != `SAO_THR_NONE
            && free >= dma_thr;
    end

    // Link synchronisers and edge finding
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ws_s_r <= `SAO_SYNC_IDLE; // Idle high, no false edge
            bc_s_r <= `SAO_SYNC_IDLE;
        end
        else
        begin
            ws_s_r <= {ws_s_r[1:0], word_sel};
            bc_s_r <= {bc_s_r[1:0], bit_clk};
        end
    end
    assign frame_start = ws_s_r[2] && !ws_s_r[1];
    assign ws_rise = !ws_s_r[2] && ws_s_r[1];
    assign bc_fall = bc_s_r[2] && !bc_s_r[1];

    // Register writes, sample assembly, status flags
    always_comb
    begin
        cfg1_nxt = cfg1_r;
        rate_nxt = rate_r;
        low_nxt = low_r;
        hi8_nxt = hi8_r;
        hi8_pend_nxt = 1'b0;
        push_v = 1'b0;
        push_data = '0;
        err_nxt = err_r;
        pend_nxt = pend_r;
        rdata_nxt = 16'h0000;
        if (hi8_pend_r)
        begin
            push_v = 1'b1;
            push_data = {hi8_r, 16'h0000};
        end
        if (reg_wr)
        begin
            case (reg_addr)
                `SAO_ADDR_CFG1: cfg1_nxt = reg_wdata & `SAO_CFG1_MASK;
                `SAO_ADDR_RATE: rate_nxt = reg_wdata & `SAO_RATE_MASK;
                `SAO_ADDR_LOWER: low_nxt = reg_wdata[7:0];
                `SAO_ADDR_UPPER:
                begin
                    push_v = 1'b1;
                    case (mode)
                        SAO_MODE_24: push_data = {reg_wdata, low_r};
                        SAO_MODE_16: push_data = {reg_wdata, 8'h00};
                        SAO_MODE_8:
                        begin
                            push_data = {reg_wdata[7:0], 16'h0000};
                            hi8_nxt = reg_wdata[15:8];
                            hi8_pend_nxt = 1'b1;
                        end
                        default: push_v = 1'b0;
                    endcase
                end
                `SAO_ADDR_STAT:
                begin
                    if (reg_wdata[`SAO_ERR_BIT])
                        err_nxt = 1'b0;
                    if (reg_wdata[`SAO_PEND_BIT])
                        pend_nxt = 1'b0;
                end
                default: ;
            endcase
        end
        if ((push_v && !fifo_rdy) || (pop_req && !pop_v))
            err_nxt = 1'b1;
        if (frame_start && en && cfg1_r[`SAO_REQ_EN_BIT] && req_cnt_r == 4'h0)
            pend_nxt = 1'b1;
        if (reg_rd)
        begin
            case (reg_addr)
                `SAO_ADDR_CFG1: rdata_nxt = cfg1_r;
                `SAO_ADDR_RATE: rdata_nxt = rate_r;
                `SAO_ADDR_STAT: rdata_nxt = {10'h000, fcount, pend_r, err_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Frame dividers, FIFO draining and shifter
    always_comb
    begin
        req_cnt_nxt = req_cnt_r;
        samp_cnt_nxt = samp_cnt_r;
        take_nxt = take_r;
        sh_nxt = sh_r;
        sd_nxt = sd_r;
        last_nxt = last_r;
        pop_req = 1'b0;
        if (!en)
        begin
            req_cnt_nxt = 4'h0;
            samp_cnt_nxt = 4'h0;
            take_nxt = 1'b0;
            sd_nxt = 1'b0;
        end
        else if (frame_start)
        begin
            req_cnt_nxt = (req_cnt_r >= req_div) ? 4'h0 : 4'(req_cnt_r + 1'b1);
            samp_cnt_nxt = (samp_cnt_r >= samp_div) ? 4'h0 : 4'(samp_cnt_r + 1'b1);
            take_nxt = (samp_cnt_r == 4'h0);
            pop_req = ch1 && samp_cnt_r == 4'h0;
            if (pop_req)
                last_nxt[0] = pop_v ? pop_data : '0;
            sh_nxt = last_nxt[0];
        end
        else if (ws_rise)
        begin
            pop_req = ch2 && take_r;
            if (pop_req)
                last_nxt[1] = pop_v ? pop_data : '0;
            sh_nxt = last_nxt[1];
        end
        else if (bc_fall)
        begin
            sd_nxt = sh_r[`SAO_SAMPLE_W-1];
            sh_nxt = {sh_r[`SAO_SAMPLE_W-2:0], 1'b0};
        end
    end

    // State registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg1_r <= `SAO_RST_VAL;
            rate_r <= `SAO_RST_VAL;
            rdata_r <= 16'h0000;
            low_r <= 8'h00;
            hi8_r <= 8'h00;
            hi8_pend_r <= 1'b0;
            err_r <= 1'b0;
            pend_r <= 1'b0;
            req_cnt_r <= 4'h0;
            samp_cnt_r <= 4'h0;
            take_r <= 1'b0;
            sh_r <= '0;
            sd_r <= 1'b0;
            last_r[0] <= '0;
            last_r[1] <= '0;
        end
        else
        begin
            cfg1_r <= cfg1_nxt;
            rate_r <= rate_nxt;
            rdata_r <= rdata_nxt;
            low_r <= low_nxt;
            hi8_r <= hi8_nxt;
            hi8_pend_r <= hi8_pend_nxt;
            err_r <= err_nxt;
            pend_r <= pend_nxt;
            req_cnt_r <= req_cnt_nxt;
            samp_cnt_r <= samp_cnt_nxt;
            take_r <= take_nxt;
            sh_r <= sh_nxt;
            sd_r <= sd_nxt;
            last_r <= last_nxt;
        end
    end

    // Output sample buffer
    sao_fifo #(.W(`SAO_SAMPLE_W), .D(`SAO_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .clr(cfg1_r[`SAO_FIFO_RST_BIT]),
        .in_valid(push_v),
        .in_ready(fifo_rdy),
        .in_data(push_data),
        .out_valid(pop_v),
        .out_ready(pop_req),
        .out_data(pop_data),
        .count(fcount)
    );

    assign reg_rdata = rdata_r;
    assign ser_data = sd_r;
    assign data_request_pending = pend_r;
    assign fifo_error_flag = err_r;

    AST_DISABLED_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
        !en |-> !dma_req ##1 !sd_r)
        else $error("disabled port active");
    AST_RSV_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        ((cfg1_r & ~`SAO_CFG1_MASK) == 16'h0000) && rate_r[15:6] == 10'h000)
        else $error("reserved bits set");
    AST_ERR_SET: assert property (@(posedge clock) disable iff (!rst_n)
        (pop_req && !pop_v) |=> err_r)
        else $error("underrun not flagged");
    AST_ERR_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
        (err_r && !(reg_wr && reg_addr == `SAO_ADDR_STAT)) |=> err_r)
        else $error("error flag dropped");
    AST_PEND_AT_FRAME: assert property (@(posedge clock) disable iff (!rst_n)
        (frame_start && en && cfg1_r[`SAO_REQ_EN_BIT] && req_cnt_r == 4'h0) |=> pend_r)
        else $error("request not raised");
    AST_DMA_THR8: assert property (@(posedge clock) disable iff (!rst_n)
        (rate_r[3:2] == 2'b10 && fcount != 4'h0) |-> !dma_req)
        else $error("dma raised without eight free");
    AST_PACK_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_wr && reg_addr == `SAO_ADDR_UPPER && mode == SAO_MODE_8)
        |=> push_v && push_data[23:16] == $past(reg_wdata[15:8]))
        else $error("high byte not pushed");
    AST_FIFO_MAX: assert property (@(posedge clock) disable iff (!rst_n)
        fcount <= 4'h8)
        else $error("fifo count above eight");
    AST_REQ_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
        (en && rate_r[5:4] == 2'b01) |-> req_cnt_r <= 4'h3)
        else $error("request divider out of range");
endmodule // sao_top

// ===== test/sao_conv_model.sv
// Behavioural model of the external audio converter on the serial link.
// Assumes the port changes ser_data on bit clock falls; clocks stand still between calls of run_frames, frames within a call run back to back.
`timescale 1ns/1ns
module sao_conv_model
    import sao_pkg::*;
(
    output logic word_sel,
    output logic bit_clk,
    input wire logic ser_data,
    output logic [31:0] ch1_bits,
    output logic [31:0] ch2_bits
);
    // ****************************************
    // Frame generator
    // ****************************************
    // Idle link: both clocks parked high
    initial
    begin
        word_sel = 1'b1;
        bit_clk = 1'b1;
        ch1_bits = 32'h0;
        ch2_bits = 32'h0;
    end

    // Plays n frames, 32 bit slots per channel, 125 ns bit period
    task automatic run_frames(input int n);
        for (int f = 0; f < n; f++)
        begin
            for (int b = 0; b < 64; b++)
            begin
                bit_clk = 1'b0;
                word_sel = (b >= 32); // Falling word select opens channel 1 slot
                #62;
                bit_clk = 1'b1;
                if (b < 32)
                begin
                    ch1_bits = {ch1_bits[30:0], ser_data}; // First bit lands at the top
                end
                else
                begin
                    ch2_bits = {ch2_bits[30:0], ser_data};
                end
                #63;
            end
        end
    endtask
endmodule // sao_conv_model

// ===== test/testbench.sv
// Self-checking bench of the serial audio output port.
// Assumes the converter model and the design files are compiled before it.
`timescale 1ns/1ns
`include "sao_consts.svh"
module testbench
    import sao_pkg::*;
;
    localparam int pin_dma = 0;
    localparam int pin_err = 1;
    localparam int pin_pend = 2;
    logic clock;
    logic rst_n;
    logic [31:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic word_sel;
    logic bit_clk;
    logic ser_data;
    logic data_request_pending;
    logic dma_req;
    logic fifo_error_flag;
    logic [31:0] ch1_bits;
    logic [31:0] ch2_bits;
    int bad_count = 0;
    int tests_run = 0;
    int k;
    int frames[4] = '{4, 8, 16, 16};
    int reqs_exp[4] = '{4, 2, 2, 1};

    // ****************************************
    // Clock, design and converter
    // ****************************************
    // System clock, 8 ns period
    initial clock = 1'b0;
    always #4 clock = ~clock;

    sao_top dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .word_sel(word_sel), .bit_clk(bit_clk), .ser_data(ser_data),
        .data_request_pending(data_request_pending), .dma_req(dma_req),
        .fifo_error_flag(fifo_error_flag));

    sao_conv_model far_u (.word_sel(word_sel), .bit_clk(bit_clk), .ser_data(ser_data),
        .ch1_bits(ch1_bits), .ch2_bits(ch2_bits));

    // ****************************************
    // Access and check tasks
    // ****************************************
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_rd(input string name, input logic [31:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(name, v, exp);
    endtask

    // Lets a register write settle, then looks at a level output
    task automatic chk_pin(input string name, input int sel, input logic exp);
        logic seen_pin;
        @(posedge clock);
        #1;
        case (sel)
            pin_dma: seen_pin = dma_req;
            pin_err: seen_pin = fifo_error_flag;
            default: seen_pin = data_request_pending;
        endcase
        chk(name, {15'h0, seen_pin}, {15'h0, exp});
    endtask

    // Word sent in the last slot of a channel, allowing up to two bits of lead-in
    function automatic logic has_word(input logic [31:0] bits, input logic [23:0] w);
        return (bits[31:8] === w) || (bits[30:7] === w) || (bits[29:6] === w);
    endfunction

    // Runs frames one by one, counting and clearing data requests
    task automatic count_reqs(input int n, output int cnt);
        logic [15:0] v;
        cnt = 0;
        repeat (n)
        begin
            far_u.run_frames(1);
            rd(`SAO_ADDR_STAT, v);
            if (v[1] === 1'b1)
            begin
                cnt++;
            end
            wr(`SAO_ADDR_STAT, 16'h0002);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    // Reset, then register, FIFO, link and rate tests
    initial
    begin
        rst_n = 1'b0;
        reg_addr = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        chk_rd("cfg1 reset", `SAO_ADDR_CFG1, 16'h0000);
        chk_rd("rate reset", `SAO_ADDR_RATE, 16'h0000);
        chk_rd("stat reset", `SAO_ADDR_STAT, 16'h0000);
        wr(`SAO_ADDR_CFG1, 16'hFFFF);
        chk_rd("cfg1 reserved", `SAO_ADDR_CFG1, 16'hFFC1);
        wr(`SAO_ADDR_RATE, 16'hFFFF);
        chk_rd("rate reserved", `SAO_ADDR_RATE, 16'h003F);
        wr(`SAO_ADDR_CFG1, 16'h0000);
        wr(`SAO_ADDR_RATE, 16'h0000);
        $display("test registers done");
        // Thresholds against free space, overrun, sticky flag
        wr(`SAO_ADDR_CFG1, 16'h2101);
        chk_pin("dma empty", pin_dma, 1'b1);
        repeat (5) wr(`SAO_ADDR_UPPER, 16'h1111);
        chk_rd("count five", `SAO_ADDR_STAT, 16'h0014);
        wr(`SAO_ADDR_RATE, 16'h0004);
        chk_pin("dma need4", pin_dma, 1'b0);
        wr(`SAO_ADDR_RATE, 16'h0008);
        chk_pin("dma need8", pin_dma, 1'b0);
        wr(`SAO_ADDR_RATE, 16'h0000);
        repeat (2) wr(`SAO_ADDR_UPPER, 16'h2222);
        chk_pin("dma free1", pin_dma, 1'b1);
        wr(`SAO_ADDR_CFG1, 16'h2201);
        chk_pin("dma free1 byte mode", pin_dma, 1'b0);
        wr(`SAO_ADDR_CFG1, 16'h2101);
        repeat (2) wr(`SAO_ADDR_UPPER, 16'h3333);
        chk_rd("overrun", `SAO_ADDR_STAT, 16'h0021);
        chk_pin("error pin", pin_err, 1'b1);
        wr(`SAO_ADDR_STAT, 16'h0001);
        chk_rd("error cleared", `SAO_ADDR_STAT, 16'h0020);
        wr(`SAO_ADDR_CFG1, 16'hA000);
        wr(`SAO_ADDR_CFG1, 16'h2000);
        chk_rd("fifo flushed", `SAO_ADDR_STAT, 16'h0000);
        chk_pin("dma disabled", pin_dma, 1'b0);
        $display("test dma and fifo done");
        // Writes per sample in the 24-bit and 8-bit widths and the reserved mode
        wr(`SAO_ADDR_CFG1, 16'h0001);
        wr(`SAO_ADDR_LOWER, 16'h0077);
        chk_rd("wide first half", `SAO_ADDR_STAT, 16'h0000);
        wr(`SAO_ADDR_UPPER, 16'h1234);
        chk_rd("wide pushed", `SAO_ADDR_STAT, 16'h0004);
        wr(`SAO_ADDR_CFG1, 16'h0201);
        wr(`SAO_ADDR_UPPER, 16'hBBAA);
        chk_rd("byte pair", `SAO_ADDR_STAT, 16'h000C);
        wr(`SAO_ADDR_CFG1, 16'h0301);
        wr(`SAO_ADDR_UPPER, 16'hCCCC);
        chk_rd("reserved mode", `SAO_ADDR_STAT, 16'h000C);
        wr(`SAO_ADDR_CFG1, 16'h8000);
        $display("test widths done");
        // Packed bytes leave in order, then the empty FIFO underruns
        wr(`SAO_ADDR_CFG1, 16'h0241);
        wr(`SAO_ADDR_UPPER, 16'h5A3C);
        far_u.run_frames(1);
        chk("low byte first", {15'h0, has_word(ch1_bits, 24'h3C0000)}, 16'h0001);
        chk_pin("no error yet", pin_err, 1'b0);
        far_u.run_frames(1);
        chk("high byte next", {15'h0, has_word(ch1_bits, 24'h5A0000)}, 16'h0001);
        far_u.run_frames(1);
        chk_pin("underrun", pin_err, 1'b1);
        wr(`SAO_ADDR_STAT, 16'h0001);
        chk_pin("underrun cleared", pin_err, 1'b0);
        // Channel 2 alone: its slot pops, channel 1 leaves the FIFO alone
        wr(`SAO_ADDR_CFG1, 16'h0181);
        repeat (2) wr(`SAO_ADDR_UPPER, 16'h1234);
        far_u.run_frames(1);
        chk("channel 2 word", {15'h0, has_word(ch2_bits, 24'h123400)}, 16'h0001);
        chk_rd("channel 1 skipped", `SAO_ADDR_STAT, 16'h0004);
        wr(`SAO_ADDR_CFG1, 16'h0000);
        $display("test serial done");
        // Request divider codes, byte mode halving, disabled port
        wr(`SAO_ADDR_CFG1, 16'h1101);
        for (int c = 0; c < 4; c++)
        begin
            wr(`SAO_ADDR_RATE, 16'(c << 4));
            count_reqs(frames[c], k);
            chk("request rate", 16'(k), 16'(reqs_exp[c]));
        end
        wr(`SAO_ADDR_RATE, 16'h0000);
        wr(`SAO_ADDR_CFG1, 16'h1201);
        count_reqs(4, k);
        chk("byte mode requests", 16'(k), 16'h0002);
        far_u.run_frames(1);
        chk_pin("pending pin", pin_pend, 1'b1);
        wr(`SAO_ADDR_STAT, 16'h0002);
        chk_pin("pending cleared", pin_pend, 1'b0);
        wr(`SAO_ADDR_CFG1, 16'h1200);
        count_reqs(4, k);
        chk("disabled requests", 16'(k), 16'h0000);
        $display("test requests done");
        // Output sampling divider drains the FIFO
        wr(`SAO_ADDR_CFG1, 16'h8100);
        wr(`SAO_ADDR_CFG1, 16'h0100);
        repeat (8) wr(`SAO_ADDR_UPPER, 16'h4444);
        wr(`SAO_ADDR_CFG1, 16'h0141);
        far_u.run_frames(4);
        chk_rd("every frame", `SAO_ADDR_STAT, 16'h0010);
        wr(`SAO_ADDR_RATE, 16'h0001);
        far_u.run_frames(8);
        chk_rd("every fourth", `SAO_ADDR_STAT, 16'h0008);
        $display("test sampling done");
        stop_test();
    end

    // Hang guard, well beyond the expected run
    initial
    begin
        #760000;
        bad_count++;
        stop_test();
    end
endmodule // testbench
